// ### include/fspf_map.vh
/*
  Constants for the status, protection and framing logic of the serial flash:
  opcodes, status bit positions, factory defaults and the busy count.
  Assumes it is included by bare name from the core file.
*/
`ifndef FSPF_MAP_VH
`define FSPF_MAP_VH

// ==========================================================================
// Opcodes
`define FSPF_OP_WREN 8'h06
`define FSPF_OP_WRDI 8'h04
`define FSPF_OP_RDSR1 8'h05
`define FSPF_OP_RDSR2 8'h35
`define FSPF_OP_WRSR 8'h01
`define FSPF_OP_PP 8'h02
`define FSPF_OP_QPP 8'h32
`define FSPF_OP_SE 8'h20
`define FSPF_OP_BE32 8'h52
`define FSPF_OP_BE64 8'hd8
`define FSPF_OP_CE1 8'hc7
`define FSPF_OP_CE2 8'h60
`define FSPF_OP_RDID 8'hab
`define FSPF_OP_MFID 8'h90
`define FSPF_OP_JDID 8'h9f

// ==========================================================================
// Status bit positions (S0..S9)
`define FSPF_S_BUSY 0
`define FSPF_S_WEL 1
`define FSPF_S_BP0 2
`define FSPF_S_BP2 4
`define FSPF_S_TB 5
`define FSPF_S_SEC 6
`define FSPF_S_PROTECT_MODE_LO 7
`define FSPF_S_PROTECT_MODE_HI 8
`define FSPF_S_QE 9

// ==========================================================================
// Factory default of the non-volatile image {qe,protect_mode_hi,protect_mode_lo,sec,tb,bp[2:0]}
`define FSPF_NV_DEFAULT 8'h00

// ==========================================================================
// Array operation kinds reported to the array
`define FSPF_K_PROG 3'h1
`define FSPF_K_ERASE4K 3'h2
`define FSPF_K_ERASE32K 3'h3
`define FSPF_K_ERASE64K 3'h4
`define FSPF_K_CHIP 3'h5
`define FSPF_K_STATUS 3'h6

// ==========================================================================
// Busy time of an internal write, in mclk_in cycles
`define FSPF_BUSY_CYC 16'd200

`endif

// ### core/fspf_status_protect.v
/*
  Status register, write protection and instruction framing of a serial flash.
  Assumes an SPI host on cs_n/sclk/serial_in, all asynchronous to mclk_in,
  with sclk slow enough (period 400 ns) for mclk_in to see every edge.
*/
`timescale 1ns/1ps
`include "fspf_map.vh"

// ==========================================================================
// Summary of operation
// - Protect mode bits held at S8 and S7
// - Mode 00: guard pin ignored, latch enables write
// - Mode 01, guard low: status write rejected
// - Mode 01, guard high: write after latch set
// - Mode 10: locked until power cycle, then 00
// - Mode 11: status register permanently unwritable
// - Quad enable at S9, switches guard pins
// - Code 000 none; small unit 4K-32K ranges
// - 32 Mbit: 64KB to 2MB, 111 all
// - 16 Mbit: 64KB to 1MB, 11x all
// - Select fall starts; opcode first, MSB first
// - Select rise completes the instruction
// - Reads may end after any bit
// - Writes abandoned unless whole bytes clocked
// - While busy only first status read (05h) accepted
// - Identity codes for ABh, 90h, 9Fh
// - Write latch S1 set, cleared on completion
// - Busy flag S0 while internal write runs
// - Guard size bits at S4..S2, default zero
module fspf_status_protect #(
  parameter DENSITY_32M = 1,
  parameter [7:0] MAKER_CODE = 8'h5a,    // Arbitrary value
  parameter [7:0] PART_CODE8 = 8'h3c,    // Arbitrary value
  parameter [15:0] PART_CODE16 = 16'h6a17 // Arbitrary value
) (
  // Clock and reset (reset acts as power cycle)
  input wire mclk_in,
  input wire rst_in,
  // Serial bus from the host
  input wire cs_n_in,
  input wire sclk_in,
  input wire serial_in_in,
  output reg serial_out_out,
  output reg serial_out_oe_n_out,
  // Write guard pin
  input wire write_guard_n_in,
  // Non-volatile image {qe,protect_mode_hi,protect_mode_lo,sec,tb,bp[2:0]}
  input wire [7:0] nv_image_in,
  output wire [7:0] nv_image_out,
  // Status and mode
  output wire [7:0] status_low_byte_out,
  output wire [7:0] status_high_byte_out,
  output wire quad_mode_out,
  // Array operation request
  output reg array_start_out,
  output reg [2:0] array_kind_out,
  output reg [23:0] array_addr_out,
  output reg refused_out
);

  localparam AW = DENSITY_32M ? 22 : 21;

  // ========================================================================
  // Protection decode: size exponent of guarded range, 0 for none
  function [4:0] fspf_exp;
    input sec;
    input [2:0] bp;
    begin
      if (bp == 3'h0)
        fspf_exp = 5'd0;
      else if (DENSITY_32M != 0 && bp == 3'h7)
        fspf_exp = 5'd22;
      else if (DENSITY_32M == 0 && bp[2:1] == 2'h3)
        fspf_exp = 5'd21;
      else if (sec)
        fspf_exp = (bp[2]) ? 5'd15 : 5'd11 + {2'h0, bp};
      else
        fspf_exp = 5'd15 + {2'h0, bp};
    end
  endfunction

  // True when addr lies inside the guarded range
  function fspf_prot;
    input [23:0] addr;
    input sec;
    input tb;
    input [2:0] bp;
    reg [4:0] e;
    reg [21:0] a;
    reg [21:0] hi;
    begin
      e = fspf_exp(sec, bp);
      a = addr[21:0] >> e;
      hi = (22'h3fffff >> (22 - AW)) >> e;
      if (e == 5'd0)
        fspf_prot = 1'b0;
      else if (tb)
        fspf_prot = (a == 22'h0);
      else
        fspf_prot = (a == hi);
    end
  endfunction

  // ========================================================================
  // Pin synchronisers
  reg [1:0] cs_sync, ck_sync, di_sync, wp_sync;
  reg cs_d, ck_d;
  always @(posedge mclk_in) begin
    if (rst_in) begin
      cs_sync <= 2'h3;
      ck_sync <= 2'h0;
      di_sync <= 2'h0;
      wp_sync <= 2'h0;
      cs_d <= 1'b1;
      ck_d <= 1'b0;
    end else begin
      cs_sync <= {cs_sync[0], cs_n_in};
      ck_sync <= {ck_sync[0], sclk_in};
      di_sync <= {di_sync[0], serial_in_in};
      wp_sync <= {wp_sync[0], write_guard_n_in};
      cs_d <= cs_sync[1];
      ck_d <= ck_sync[1];
    end
  end

  wire cs_fall = cs_d & ~cs_sync[1];
  wire cs_rise = ~cs_d & cs_sync[1];
  wire ck_rise = ~cs_sync[1] & ~ck_d & ck_sync[1];
  wire ck_fall = ~cs_sync[1] & ck_d & ~ck_sync[1];

  // ========================================================================
  // Status bits
  reg busy, write_latch, protect_mode_hi, protect_mode_lo, sec, tb, qe;
  reg [2:0] bp;
  reg [15:0] busy_cnt;

  assign status_low_byte_out = {protect_mode_lo, sec, tb, bp, write_latch, busy};
  assign status_high_byte_out = {6'h00, qe, protect_mode_hi};
  assign nv_image_out = {qe, protect_mode_hi, protect_mode_lo, sec, tb, bp};
  assign quad_mode_out = qe;

  // ========================================================================
  // Framing: bit count, opcode, address and data capture
  reg [11:0] bit_cnt;
  reg [7:0] opcode;
  reg cmd_ok;
  reg [23:0] shift_in;
  reg [23:0] addr;
  reg [7:0] wr_lo, wr_hi;
  wire [23:0] next_shift = {shift_in[22:0], di_sync[1]};

  // Select fall opens a frame; bits shift in on sclk rise, MSB first
  always @(posedge mclk_in) begin
    if (rst_in) begin
      bit_cnt <= 12'h000;
      opcode <= 8'h00;
      cmd_ok <= 1'b0;
      shift_in <= 24'h000000;
      addr <= 24'h000000;
      wr_lo <= 8'h00;
      wr_hi <= 8'h00;
    end else if (cs_fall) begin
      bit_cnt <= 12'h000;
      cmd_ok <= 1'b0;
    end else if (ck_rise) begin
      shift_in <= next_shift;
      if (bit_cnt != 12'hfff)
        bit_cnt <= bit_cnt + 12'h001;
      if (bit_cnt == 12'd7) begin
        opcode <= next_shift[7:0];
        cmd_ok <= ~busy | (next_shift[7:0] == `FSPF_OP_RDSR1);
      end
      if (bit_cnt == 12'd15)
        wr_lo <= next_shift[7:0];
      if (bit_cnt == 12'd23)
        wr_hi <= next_shift[7:0];
      if (bit_cnt == 12'd31)
        addr <= next_shift;
    end
  end

  // ========================================================================
  // Read data: byte chosen by opcode and byte index
  wire [8:0] byte_idx = bit_cnt[11:3];
  reg [7:0] tx_byte;
  reg tx_on;
  always @* begin
    tx_byte = 8'h00;
    tx_on = 1'b0;
    case (opcode)
      `FSPF_OP_RDSR1: begin
        tx_byte = status_low_byte_out;
        tx_on = (byte_idx != 9'd0);
      end
      `FSPF_OP_RDSR2: begin
        tx_byte = status_high_byte_out;
        tx_on = (byte_idx != 9'd0);
      end
      `FSPF_OP_RDID: begin
        tx_byte = PART_CODE8;
        tx_on = (byte_idx >= 9'd4);
      end
      `FSPF_OP_MFID: begin
        tx_byte = byte_idx[0] ? PART_CODE8 : MAKER_CODE;
        tx_on = (byte_idx >= 9'd4);
      end
      `FSPF_OP_JDID: begin
        tx_on = (byte_idx != 9'd0);
        case (byte_idx)
          9'd1: tx_byte = MAKER_CODE;
          9'd2: tx_byte = PART_CODE16[15:8];
          9'd3: tx_byte = PART_CODE16[7:0];
          default: tx_byte = 8'h00;
        endcase
      end
      default: tx_on = 1'b0;
    endcase
  end

  // Output bit changes on sclk fall; released as soon as select rises
  always @(posedge mclk_in) begin
    if (rst_in) begin
      serial_out_out <= 1'b0;
      serial_out_oe_n_out <= 1'b1;
    end else if (cs_sync[1]) begin
      serial_out_oe_n_out <= 1'b1;
    end else if (ck_fall) begin
      serial_out_out <= tx_byte[3'h7 - bit_cnt[2:0]];
      serial_out_oe_n_out <= ~(tx_on & cmd_ok);
    end
  end

  // ========================================================================
  // Completion at select rise
  wire aligned = (bit_cnt[2:0] == 3'h0) && (bit_cnt != 12'h000);
  wire [1:0] pmode = {protect_mode_hi, protect_mode_lo};
  wire guard_open = wp_sync[1] | qe; // Quad line 2 replaces the guard pin
  wire sr_ok = write_latch && (pmode == 2'b00 || (pmode == 2'b01 && guard_open));
  wire hit = fspf_prot(addr, sec, tb, bp);
  reg go;
  reg deny;
  reg [2:0] kind;
  always @* begin
    go = 1'b0;
    deny = 1'b0;
    kind = `FSPF_K_PROG;
    if (cs_rise && cmd_ok && aligned) begin
      case (opcode)
        `FSPF_OP_WRSR: begin
          kind = `FSPF_K_STATUS;
          if (bit_cnt == 12'd16 || bit_cnt == 12'd24) begin
            go = sr_ok;
            deny = ~sr_ok;
          end
        end
        `FSPF_OP_PP, `FSPF_OP_QPP: begin
          kind = `FSPF_K_PROG;
          if (bit_cnt >= 12'd40 && write_latch) begin
            go = ~hit;
            deny = hit;
          end
        end
        `FSPF_OP_SE, `FSPF_OP_BE32, `FSPF_OP_BE64: begin
          kind = (opcode == `FSPF_OP_SE) ? `FSPF_K_ERASE4K :
                 (opcode == `FSPF_OP_BE32) ? `FSPF_K_ERASE32K : `FSPF_K_ERASE64K;
          if (bit_cnt == 12'd32 && write_latch) begin
            go = ~hit;
            deny = hit;
          end
        end
        `FSPF_OP_CE1, `FSPF_OP_CE2: begin
          kind = `FSPF_K_CHIP;
          if (bit_cnt == 12'd8 && write_latch) begin
            go = (bp == 3'h0);
            deny = (bp != 3'h0);
          end
        end
        default: go = 1'b0;
      endcase
    end
  end

  // Status register, write latch and busy timer
  always @(posedge mclk_in) begin
    if (rst_in) begin
      busy <= 1'b0;
      write_latch <= 1'b0;
      busy_cnt <= 16'h0000;
      {qe, sec, tb, bp} <= {nv_image_in[7], nv_image_in[4:0]};
      if (nv_image_in[6:5] == 2'b10)
        {protect_mode_hi, protect_mode_lo} <= 2'b00;
      else
        {protect_mode_hi, protect_mode_lo} <= nv_image_in[6:5];
    end else if (busy) begin
      if (busy_cnt == 16'h0001) begin
        busy <= 1'b0;
        write_latch <= 1'b0;
      end
      busy_cnt <= busy_cnt - 16'h0001;
    end else if (go) begin
      busy <= 1'b1;
      busy_cnt <= `FSPF_BUSY_CYC;
      if (opcode == `FSPF_OP_WRSR) begin
        {protect_mode_lo, sec, tb, bp} <= wr_lo[7:2];
        if (bit_cnt == 12'd24) begin
          qe <= wr_hi[1];
          protect_mode_hi <= wr_hi[0];
        end
      end
    end else if (cs_rise && cmd_ok && bit_cnt == 12'd8) begin
      if (opcode == `FSPF_OP_WREN)
        write_latch <= 1'b1;
      else if (opcode == `FSPF_OP_WRDI)
        write_latch <= 1'b0;
    end
  end

  // Array request pulse and refusal pulse
  always @(posedge mclk_in) begin
    if (rst_in) begin
      array_start_out <= 1'b0;
      array_kind_out <= 3'h0;
      array_addr_out <= 24'h000000;
      refused_out <= 1'b0;
    end else begin
      array_start_out <= go && (kind != `FSPF_K_STATUS);
      refused_out <= deny;
      if (go) begin
        array_kind_out <= kind;
        array_addr_out <= addr;
      end
    end
  end

endmodule // fspf_status_protect

// ### tb/fspf_host_model.sv
/* SPI host model: mode 0 frames on select, clock and data.
   Assumes the device answers after clock falls; the model samples before each rise. */
`timescale 1ns/1ps
// ==========================================================================
// Host model
module fspf_host_model (
  // Serial bus
  output logic cs_n_out,
  output logic sclk_out,
  output logic sdi_out,
  input wire sdo_in
);
  // Idle: deselected, clock still between frames
  initial begin
    cs_n_out = 1'b1;
    sclk_out = 1'b0;
    sdi_out = 1'b0;
  end

  // One frame of n bits, MSB first, data set while the clock is low
  task automatic xfer(input int n, input logic [47:0] d, output logic [47:0] q);
    q = '0;
    cs_n_out = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      sdi_out = d[i];
      #250 q = {q[46:0], sdo_in};
      sclk_out = 1'b1;
      #150 sclk_out = 1'b0;
    end
    #250 cs_n_out = 1'b1;
    sdi_out = ~sdi_out; // Released line shows no stale bit
    #400;
  endtask
endmodule // fspf_host_model

// ### tb/fspf_checker.sv
/* Checker: assertions on the status core's ports.
   Assumes one clock domain with a synchronous active-high reset. */
`timescale 1ns/1ps
// ==========================================================================
// Checker
module fspf_checker (
  // Clock and reset
  input wire mclk_in,
  input wire rst_in,
  // Watched signals
  input wire cs_n_in,
  input wire serial_out_oe_n_out,
  input wire [7:0] nv_image_out,
  input wire [7:0] status_low_byte_out,
  input wire [7:0] status_high_byte_out,
  input wire quad_mode_out,
  input wire array_start_out,
  input wire refused_out
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (rst_in);
  // Busy and latch bits
  wire busy = status_low_byte_out[0];
  wire write_latch = status_low_byte_out[1];

  property p_ref_alone; refused_out |-> !array_start_out; endproperty
  a_ref_alone: assert property (p_ref_alone) else $error("refused op also started");
  property p_start_busy; array_start_out |-> write_latch ##[1:3] busy [*4]; endproperty
  a_start_busy: assert property (p_start_busy) else $error("start without latch or busy");
  property p_latch_clr; $fell(busy) |-> !write_latch; endproperty
  a_latch_clr: assert property (p_latch_clr) else $error("latch kept after busy");
  property p_quad; quad_mode_out == status_high_byte_out[1] && (!$changed(quad_mode_out) || busy); endproperty
  a_quad: assert property (p_quad) else $error("quad mode differs from bit");
  property p_nv_map;
    nv_image_out == {status_high_byte_out[1:0], status_low_byte_out[7:2]} && status_high_byte_out[7:2] == 6'h00
      && (!$changed(nv_image_out) || busy);
  endproperty
  a_nv_map: assert property (p_nv_map) else $error("image and status differ");
  property p_release; cs_n_in [*8] |-> serial_out_oe_n_out; endproperty
  a_release: assert property (p_release) else $error("output driven while deselected");
  property p_otp; status_high_byte_out[0] && status_low_byte_out[7] |=> $stable(nv_image_out); endproperty
  a_otp: assert property (p_otp) else $error("locked status changed");
  property p_ref_keep; refused_out |=> $stable(status_low_byte_out[7:2]); endproperty
  a_ref_keep: assert property (p_ref_keep) else $error("refused write changed bits");

  // Main scenarios
  c_start: cover property (array_start_out);
  c_ref: cover property (refused_out);
  c_lock: cover property (status_high_byte_out[0] && !status_low_byte_out[7]);
endmodule // fspf_checker

bind fspf_status_protect fspf_checker i_chk (.mclk_in, .rst_in, .cs_n_in, .serial_out_oe_n_out, .nv_image_out,
  .status_low_byte_out, .status_high_byte_out, .quad_mode_out, .array_start_out, .refused_out);

// ### tb/fspf_status_protect_tb_top.sv
/* Bench for the status core: protection map, write modes, framing, identity.
   Assumes the host model and checker in tb/ and the 200-cycle busy time. */
`timescale 1ns/1ps
// ==========================================================================
// Bench top
module fspf_status_protect_tb_top;
  localparam logic [7:0] MK = 8'h5a; // Arbitrary value
  localparam logic [7:0] P8 = 8'h3c; // Arbitrary value
  localparam logic [15:0] P16 = 16'h6a17; // Arbitrary value
  logic mclk_in = 1'b0;
  logic rst_in = 1'b1;
  logic guard_n = 1'b1;
  logic [7:0] nv_in = 8'h00;
  logic [7:0] nv;
  logic g, w, e, got_ref, got_start, saw_oe;
  logic [23:0] a;
  logic [47:0] q;
  wire cs_n, sclk, sdi, sdo, oe_n, quad, start, refused;
  wire [7:0] nv_o, st_lo, st_hi;
  wire [2:0] kind;
  wire [23:0] addr;
  wire sdo_line = oe_n ? ~sdo : sdo; // Released line shows the inverse of its last bit
  int error_cnt = 0;
  int n_compared = 0;
  // Rows: image, guard, status write, address, refused
  logic [34:0] rows [14] = '{
    {8'h00, 2'b01, 24'h0, 1'b0}, {8'h20, 2'b01, 24'h0, 1'b1}, {8'h20, 2'b11, 24'h0, 1'b0},
    {8'h60, 2'b11, 24'h0, 1'b1}, {8'h00, 2'b10, 24'h3fffff, 1'b0}, {8'h01, 2'b10, 24'h3f0000, 1'b1},
    {8'h01, 2'b10, 24'h3effff, 1'b0}, {8'h06, 2'b10, 24'h200000, 1'b1}, {8'h0e, 2'b10, 24'h200000, 1'b0},
    {8'h07, 2'b10, 24'h000000, 1'b1}, {8'h11, 2'b10, 24'h3fefff, 1'b0}, {8'h1c, 2'b10, 24'h007fff, 1'b1},
    {8'h1c, 2'b10, 24'h008000, 1'b0}, {8'ha0, 2'b01, 24'h0, 1'b0}};

  fspf_status_protect #(.DENSITY_32M(1), .MAKER_CODE(MK), .PART_CODE8(P8), .PART_CODE16(P16)) i_dut (
    .mclk_in(mclk_in), .rst_in(rst_in), .cs_n_in(cs_n), .sclk_in(sclk), .serial_in_in(sdi),
    .serial_out_out(sdo), .serial_out_oe_n_out(oe_n), .write_guard_n_in(guard_n), .nv_image_in(nv_in),
    .nv_image_out(nv_o), .status_low_byte_out(st_lo), .status_high_byte_out(st_hi), .quad_mode_out(quad),
    .array_start_out(start), .array_kind_out(kind), .array_addr_out(addr), .refused_out(refused));
  fspf_host_model i_host (.cs_n_out(cs_n), .sclk_out(sclk), .sdi_out(sdi), .sdo_in(sdo_line));

  // Clock
  always #25 mclk_in = ~mclk_in;

  // Catch one-cycle pulses and any drive of the data line
  always @(posedge mclk_in) begin
    if (refused === 1'b1) got_ref <= 1'b1;
    if (start === 1'b1) got_start <= 1'b1;
    if (oe_n === 1'b0) saw_oe <= 1'b1;
  end

  task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict;
    $display("compared=%0d errors=%0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // Power cycle with a given image
  task automatic boot(input logic [7:0] img);
    @(negedge mclk_in);
    nv_in = img;
    rst_in = 1'b1;
    repeat (5) @(negedge mclk_in);
    rst_in = 1'b0;
    repeat (4) @(negedge mclk_in);
  endtask

  task automatic frm(input int n, input logic [47:0] d);
    i_host.xfer(n, d, q);
  endtask

  task automatic idle;
    for (int i = 0; i < 400 && st_lo[0] !== 1'b0; i++) @(negedge mclk_in);
  endtask

  // Main sequence
  initial begin
    foreach (rows[r]) begin
      {nv, g, w, a, e} = rows[r];
      guard_n = g;
      boot(nv);
      {got_ref, got_start} = 2'b00;
      frm(8, 8'h06);
      frm(w ? 16 : 32, w ? 48'h011c : {8'h20, a});
      idle;
      frm(16, 16'h0500);
      chk(got_ref, e);
      if (!w) chk(got_start, !e);
      if (!w && !e) chk({kind, addr}, {3'h2, a});
      chk(q[7:0], w && !e ? 8'h1c : {nv[5:0], e, 1'b0});
      $display("row %0d done", r);
    end
    // Lockdown until power cycle, quad enable kept
    boot(8'h00);
    frm(8, 8'h06);
    frm(24, 24'h010003); // Mode 00 after boot ignores the guard pin, held low here, so quad enable may be set
    idle;
    chk({quad, st_hi}, 9'h103);
    frm(8, 8'h06);
    frm(16, 16'h011c);
    idle;
    chk(st_lo, 8'h02);
    boot(nv_o);
    chk(nv_o, 8'h80);
    $display("lockdown test done");
    // Partial write frame, busy lockout, identity reads
    frm(8, 8'h06);
    got_start = 1'b0;
    frm(31, 31'h10000000);
    chk({got_start, st_lo}, 9'h002);
    frm(32, 32'h20000000);
    saw_oe = 1'b0;
    chk(st_lo[1:0], 2'b11);
    frm(16, 16'h9f00);
    chk(saw_oe, 1'b0);
    idle;
    chk(st_lo, 8'h00);
    frm(11, 11'h028);
    frm(32, 32'h9f000000);
    chk(q[23:0], {MK, P16});
    frm(40, 40'hab00000000);
    chk(q[7:0], P8);
    frm(48, 48'h900000000000);
    chk(q[15:0], {MK, P8});
    $display("framing test done");
    // Second status byte, write disable, program, block erase, refused chip erase
    frm(16, 16'h3500);
    chk(q[7:0], 8'h02);
    frm(8, 8'h06);
    frm(8, 8'h04);
    chk(st_lo, 8'h00);
    frm(8, 8'h06);
    got_start = 1'b0;
    frm(40, 40'h02001234a5);
    chk({got_start, kind, addr}, {1'b1, 3'h1, 24'h001234});
    idle;
    frm(8, 8'h06);
    frm(32, 32'hd8010000);
    frm(16, 16'h0500);
    chk({kind, q[7:0]}, {3'h4, 8'h03});
    idle;
    frm(8, 8'h06);
    frm(16, 16'h0104);
    idle;
    frm(8, 8'h06);
    {got_ref, got_start} = 2'b00;
    frm(8, 8'hc7);
    chk({got_ref, got_start, st_lo}, {2'b10, 8'h06});
    $display("opcode test done");
    print_verdict;
  end

  // Cut a hang short
  initial begin
    #3000000;
    error_cnt++;
    print_verdict;
  end
endmodule // fspf_status_protect_tb_top
